// file: hw/wptx_pkg.sv
/*
 * Package for the power transmitter phase controller: packet headers,
 * frequency and duty figures, timing constants and phase states.
 * Assumes a 50 MHz system clock.
 */
package wptx_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 50_000_000;
	localparam int SEL_PINGS_PER_SEC = 2;
	localparam int SEL_PERIOD_CYC = CLK_HZ / SEL_PINGS_PER_SEC;
	localparam int BURST_US = 100;
	localparam int BURST_CYC = (BURST_US * (CLK_HZ / 1_000_000));

	// ----------------------------------------------------------------
	// Inverter operating point, in kHz and percent
	// ----------------------------------------------------------------
	localparam logic [7:0] FREQ_MIN_KHZ = 8'd110;
	localparam logic [7:0] FREQ_MAX_KHZ = 8'd205;
	localparam logic [7:0] FREQ_PING_KHZ = 8'd175;
	localparam logic [6:0] DUTY_NOM_PCT = 7'd50;
	localparam logic [6:0] DUTY_MIN_PCT = 7'd10;

	// ----------------------------------------------------------------
	// Packet headers
	// ----------------------------------------------------------------
	localparam logic [7:0] HDR_SIG_STRENGTH = 8'h01;
	localparam logic [7:0] HDR_END_POWER = 8'h02;
	localparam logic [7:0] HDR_CTRL_ERROR = 8'h03;
	localparam logic [7:0] HDR_RECT_POWER = 8'h04;
	localparam logic [7:0] HDR_CHARGE_STAT = 8'h05;
	localparam logic [7:0] HDR_HOLD_OFF = 8'h06;
	localparam logic [7:0] HDR_PROP_A = 8'h18;
	localparam logic [7:0] HDR_PROP_B = 8'hF2;
	localparam logic [7:0] HDR_IDENT = 8'h71;
	localparam logic [7:0] HDR_EXT_IDENT = 8'h81;
	localparam logic [7:0] HDR_CONFIG = 8'h51;
	localparam int IDENT_EXT_BIT = 7;
	localparam logic [2:0] MAX_OPT_PKTS = 3'd7;

	// ----------------------------------------------------------------
	// Phases
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		PH_SLEEP,
		PH_SELECT,
		PH_PING,
		PH_IDCFG,
		PH_POWER,
		PH_REMOVE
	} wptx_phase_e;

	typedef enum logic [1:0] {
		IC_IDENT,
		IC_EXT,
		IC_OPT
	} wptx_idcfg_e;

endpackage : wptx_pkg

// file: hw/wptx_phase_ctrl.sv
/*
 * Phase controller for an inductive power transmitter. Sequences the
 * selection, ping, identification/configuration and power transfer phases,
 * checks packet order and timeouts, and sets the inverter operating point.
 * Assumes a demodulator on the same clock delivers start-bit pulses and whole
 * checksum-valid packets (header plus first message byte) as one-cycle strobes.
 */
// Function
// RULE1: Keep switching frequency between 110 kHz and 205 kHz while regulating power.
// RULE2: At the 205 kHz limit, regulate further by changing duty cycle.
// RULE3: While reset is high, force all control state to defaults.
// RULE4: On reset release, start operation from the initial state.
// RULE5: Active-low enable high means sleep; low means active.
// RULE6: Phases run selection, ping, identification/configuration, power transfer.
// RULE7: Selection sends a brief coil burst twice per second and listens.
// RULE8: Ping drives 175 kHz at 50 percent duty.
// RULE9: Missing signal-strength start bit in ping removes power after a delay.
// RULE10: Signal-strength packet advances to ID/config; other packet terminates power.
// RULE11: Receiver encodes signal strength as unsigned 0 to 255.
// RULE12: ID packet, extended ID if flagged, then configuration packet.
// RULE13: Operating point stays 175 kHz and 50 percent during ID/config.
// RULE14: Up to seven optional hold-off, proprietary or reserved packets before configuration.
// RULE15: Late start bit, late or out-of-sequence packet removes power after a delay.
// RULE16: Power transfer accepts control error, rectified power, charge, end, other packets.
// RULE17: Late first or subsequent control-error packet removes power.
// RULE18: Rectified-power packet must arrive in time after configuration, else remove power.
// RULE19: Wait a settling delay after control error before changing operating point.
// RULE20: Correct packet breaking sequence in power transfer removes power.
// RULE21: Packets are preamble, header, message, checksum.
// RULE22: Timeout windows and removal delay are parameters.
// RULE23: End-power packet removes power and returns to selection.
`timescale 1ns/100ps
`default_nettype none

module wptx_phase_ctrl #(
	parameter int PING_TMO_CYC = 1_000_000, // see RULE22
	parameter int NEXT_TMO_CYC = 1_000_000,
	parameter int CE_FIRST_TMO_CYC = 1_000_000,
	parameter int CE_TMO_CYC = 1_000_000,
	parameter int RP_TMO_CYC = 1_000_000,
	parameter int REMOVE_DLY_CYC = 20,
	parameter int SETTLE_CYC = 20
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Pin input
	input wire logic enable_n,
	// Demodulator, same clock
	input wire logic rx_start_bit,
	input wire logic rx_pkt_valid,
	input wire logic [7:0] rx_header, // see RULE21
	input wire logic [7:0] rx_msg0,
	// Selection sensing, same clock
	input wire logic sense_resp,
	// Inverter operating point
	output logic coil_drive_en,
	output logic [7:0] freq_khz,
	output logic [6:0] duty_pct,
	// Status
	output logic sleep_mode,
	output logic [2:0] phase,
	output logic [7:0] sig_strength
);

	// ----------------------------------------------------------------
	// Pin synchroniser and state
	// ----------------------------------------------------------------
	logic en_n_meta;
	logic en_n_sync;
	wptx_pkg::wptx_phase_e state;
	wptx_pkg::wptx_idcfg_e ic_step;
	logic [24:0] sel_cnt;
	logic [31:0] tmo_cnt;
	logic [31:0] rp_cnt;
	logic rp_pending;
	logic started;
	logic [2:0] opt_cnt;
	logic [31:0] settle_cnt;
	logic settle_busy;
	logic signed [7:0] ce_val;
	logic burst_active;
	logic [31:0] burst_cnt;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			// Reset to the enabled level so no sleep pulse follows reset.
			en_n_meta <= 1'b0;
			en_n_sync <= 1'b0;
		end else begin
			en_n_meta <= enable_n;
			en_n_sync <= en_n_meta;
		end
	end

	// ----------------------------------------------------------------
	// Packet classification
	// ----------------------------------------------------------------
	logic pkt_optional;
	logic pkt_end;
	logic pkt_ce;
	logic pkt_rp;
	logic pkt_pt_ok;
	logic hdr_known_req;
	always_comb begin
		pkt_end = rx_pkt_valid && (rx_header == wptx_pkg::HDR_END_POWER);
		pkt_ce = rx_pkt_valid && (rx_header == wptx_pkg::HDR_CTRL_ERROR);
		pkt_rp = rx_pkt_valid && (rx_header == wptx_pkg::HDR_RECT_POWER);
		// Headers with a fixed role in the sequence are not optional/reserved.
		hdr_known_req = (rx_header == wptx_pkg::HDR_SIG_STRENGTH) || (rx_header == wptx_pkg::HDR_IDENT)
			|| (rx_header == wptx_pkg::HDR_EXT_IDENT) || (rx_header == wptx_pkg::HDR_CONFIG)
			|| (rx_header == wptx_pkg::HDR_END_POWER) || (rx_header == wptx_pkg::HDR_CTRL_ERROR)
			|| (rx_header == wptx_pkg::HDR_RECT_POWER) || (rx_header == wptx_pkg::HDR_CHARGE_STAT);
		pkt_optional = !hdr_known_req; // see RULE14
		// Power transfer accepts all but the ping and ID/config headers.
		pkt_pt_ok = (rx_header != wptx_pkg::HDR_SIG_STRENGTH) && (rx_header != wptx_pkg::HDR_IDENT)
			&& (rx_header != wptx_pkg::HDR_EXT_IDENT) && (rx_header != wptx_pkg::HDR_CONFIG); // see RULE16
	end

	// ----------------------------------------------------------------
	// Phase sequencer
	// ----------------------------------------------------------------
	logic tmo_hit;
	assign tmo_hit = (tmo_cnt == 32'd0);

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin // see RULE3
			state <= wptx_pkg::PH_SELECT; // see RULE4
			ic_step <= wptx_pkg::IC_IDENT;
			opt_cnt <= 3'd0;
			started <= 1'b0;
			tmo_cnt <= 32'd0;
			rp_pending <= 1'b0;
			rp_cnt <= 32'd0;
			sig_strength <= 8'h00;
		end else if (en_n_sync) begin // see RULE5
			state <= wptx_pkg::PH_SLEEP;
			rp_pending <= 1'b0;
		end else begin
			unique case (state) // see RULE6
				wptx_pkg::PH_SLEEP: begin
					state <= wptx_pkg::PH_SELECT;
				end
				wptx_pkg::PH_SELECT: begin
					if (burst_active && sense_resp) begin // see RULE7
						state <= wptx_pkg::PH_PING;
						started <= 1'b0;
						tmo_cnt <= 32'(PING_TMO_CYC);
					end
				end
				wptx_pkg::PH_PING: begin
					if (rx_start_bit)
						started <= 1'b1;
					if (rx_pkt_valid) begin
						if (rx_header == wptx_pkg::HDR_SIG_STRENGTH) begin // see RULE10
							sig_strength <= rx_msg0; // see RULE11
							state <= wptx_pkg::PH_IDCFG;
							ic_step <= wptx_pkg::IC_IDENT;
							opt_cnt <= 3'd0;
							started <= 1'b0;
							tmo_cnt <= 32'(NEXT_TMO_CYC);
						end else begin
							state <= wptx_pkg::PH_REMOVE;
							tmo_cnt <= 32'(REMOVE_DLY_CYC);
						end
					end else if (!started && tmo_hit) begin // see RULE9
						state <= wptx_pkg::PH_REMOVE;
						tmo_cnt <= 32'(REMOVE_DLY_CYC);
					end else if (!started) begin
						tmo_cnt <= tmo_cnt - 32'd1;
					end
				end
				wptx_pkg::PH_IDCFG: begin
					if (rx_start_bit)
						started <= 1'b1;
					if (rx_pkt_valid) begin // see RULE12
						started <= 1'b0;
						tmo_cnt <= 32'(NEXT_TMO_CYC);
						if (ic_step == wptx_pkg::IC_IDENT && rx_header == wptx_pkg::HDR_IDENT) begin
							ic_step <= rx_msg0[wptx_pkg::IDENT_EXT_BIT] ? wptx_pkg::IC_EXT : wptx_pkg::IC_OPT;
						end else if (ic_step == wptx_pkg::IC_EXT && rx_header == wptx_pkg::HDR_EXT_IDENT) begin
							ic_step <= wptx_pkg::IC_OPT;
						end else if (ic_step == wptx_pkg::IC_OPT && pkt_optional
							&& opt_cnt < wptx_pkg::MAX_OPT_PKTS) begin // see RULE14
							opt_cnt <= opt_cnt + 3'd1;
						end else if (ic_step == wptx_pkg::IC_OPT && rx_header == wptx_pkg::HDR_CONFIG) begin
							state <= wptx_pkg::PH_POWER;
							tmo_cnt <= 32'(CE_FIRST_TMO_CYC);
							rp_pending <= 1'b1; // see RULE18
							rp_cnt <= 32'(RP_TMO_CYC);
						end else begin // see RULE15
							state <= wptx_pkg::PH_REMOVE;
							tmo_cnt <= 32'(REMOVE_DLY_CYC);
						end
					end else if (!started && tmo_hit) begin // see RULE15
						state <= wptx_pkg::PH_REMOVE;
						tmo_cnt <= 32'(REMOVE_DLY_CYC);
					end else if (!started) begin
						tmo_cnt <= tmo_cnt - 32'd1;
					end
				end
				wptx_pkg::PH_POWER: begin
					if (pkt_end) begin // see RULE23
						state <= wptx_pkg::PH_SELECT;
						rp_pending <= 1'b0;
					end else if (rx_pkt_valid && !pkt_pt_ok) begin // see RULE20
						state <= wptx_pkg::PH_SELECT;
						rp_pending <= 1'b0;
					end else if (tmo_hit || (rp_pending && rp_cnt == 32'd0)) begin // see RULE17
						state <= wptx_pkg::PH_SELECT;
						rp_pending <= 1'b0;
					end else begin
						tmo_cnt <= pkt_ce ? 32'(CE_TMO_CYC) : tmo_cnt - 32'd1; // see RULE17
						if (pkt_rp)
							rp_pending <= 1'b0; // see RULE18
						else if (rp_pending)
							rp_cnt <= rp_cnt - 32'd1;
					end
				end
				wptx_pkg::PH_REMOVE: begin
					if (tmo_hit)
						state <= wptx_pkg::PH_SELECT;
					else
						tmo_cnt <= tmo_cnt - 32'd1;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Selection burst timer
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (sys_rst || state != wptx_pkg::PH_SELECT) begin
			sel_cnt <= 25'd0;
			burst_cnt <= 32'd0;
			burst_active <= 1'b0;
		end else if (sel_cnt == 25'd0) begin // see RULE7
			// A burst opens each selection period, the first one on entry.
			sel_cnt <= 25'd1;
			burst_active <= 1'b1;
			burst_cnt <= 32'(wptx_pkg::BURST_CYC - 1);
		end else begin
			if (sel_cnt == 25'(wptx_pkg::SEL_PERIOD_CYC - 1))
				sel_cnt <= 25'd0;
			else
				sel_cnt <= sel_cnt + 25'd1;
			if (burst_cnt != 32'd0)
				burst_cnt <= burst_cnt - 32'd1;
			else
				burst_active <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Control-error settling and operating point
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (sys_rst || state != wptx_pkg::PH_POWER) begin
			settle_busy <= 1'b0;
			settle_cnt <= 32'd0;
			ce_val <= 8'sd0;
		end else if (pkt_ce) begin // see RULE19
			settle_busy <= 1'b1;
			settle_cnt <= 32'(SETTLE_CYC);
			ce_val <= signed'(rx_msg0);
		end else if (settle_busy) begin
			if (settle_cnt == 32'd0)
				settle_busy <= 1'b0;
			else
				settle_cnt <= settle_cnt - 32'd1;
		end
	end

	logic apply_ce;
	// A fresh control error restarts the wait rather than applying the old one.
	assign apply_ce = settle_busy && (settle_cnt == 32'd0) && !pkt_ce; // see RULE19

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			freq_khz <= wptx_pkg::FREQ_PING_KHZ;
			duty_pct <= wptx_pkg::DUTY_NOM_PCT;
		end else if (state != wptx_pkg::PH_POWER) begin // see RULE8
			freq_khz <= wptx_pkg::FREQ_PING_KHZ; // see RULE13
			duty_pct <= wptx_pkg::DUTY_NOM_PCT;
		end else if (apply_ce && ce_val > 0) begin
			// More power: lower frequency, but first restore duty.
			if (duty_pct < wptx_pkg::DUTY_NOM_PCT)
				duty_pct <= duty_pct + 7'd1;
			else if (freq_khz > wptx_pkg::FREQ_MIN_KHZ) // see RULE1
				freq_khz <= freq_khz - 8'd1;
		end else if (apply_ce && ce_val < 0) begin
			if (freq_khz < wptx_pkg::FREQ_MAX_KHZ) // see RULE1
				freq_khz <= freq_khz + 8'd1;
			else if (duty_pct > wptx_pkg::DUTY_MIN_PCT) // see RULE2
				duty_pct <= duty_pct - 7'd1;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			coil_drive_en <= 1'b0;
			sleep_mode <= 1'b0;
			phase <= 3'd0;
		end else begin
			coil_drive_en <= (state == wptx_pkg::PH_PING) || (state == wptx_pkg::PH_IDCFG)
				|| (state == wptx_pkg::PH_POWER) || (state == wptx_pkg::PH_REMOVE)
				|| (state == wptx_pkg::PH_SELECT && burst_active);
			sleep_mode <= (state == wptx_pkg::PH_SLEEP);
			phase <= 3'(state);
		end
	end

endmodule : wptx_phase_ctrl

`default_nettype wire

// file: test/wptx_chk.sv
/* Port checker for the transmitter phase controller, bound to every instance.
 * Assumes the single clk_sys domain and the synchronous active-high sys_rst. */
`timescale 1ns/100ps
`default_nettype none
module wptx_chk (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Inputs
	input wire logic enable_n,
	input wire logic rx_pkt_valid,
	input wire logic [7:0] rx_header,
	// Outputs
	input wire logic coil_drive_en,
	input wire logic [7:0] freq_khz,
	input wire logic [6:0] duty_pct,
	input wire logic sleep_mode,
	input wire logic [2:0] phase
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);
	logic pkt_ping;
	logic pkt_pwr;
	assign pkt_ping = rx_pkt_valid && phase == 3'h2;
	assign pkt_pwr = rx_pkt_valid && phase == 3'h4;
	a_freq_band: assert property (coil_drive_en |-> freq_khz inside {[8'h6E:8'hCD]})
		else $error("frequency out of band");
	a_duty_floor: assert property (duty_pct < 7'h32 |-> freq_khz == 8'hCD)
		else $error("duty cut below top frequency");
	a_reset_dflt: assert property (disable iff (1'b0) sys_rst ##1 1'b1 |-> !coil_drive_en
		&& freq_khz == 8'hAF && duty_pct == 7'h32 && !sleep_mode) else $error("reset defaults wrong");
	a_sleep_enter: assert property (enable_n [*6] |-> sleep_mode && !coil_drive_en)
		else $error("not asleep while disabled");
	a_sleep_leave: assert property (!enable_n [*6] |-> !sleep_mode)
		else $error("asleep while enabled");
	a_ping_point: assert property (phase inside {3'h2, 3'h3} |-> freq_khz == 8'hAF && duty_pct == 7'h32)
		else $error("operating point moved in ping or setup");
	a_coil_live: assert property (phase inside {3'h2, 3'h3, 3'h4} |-> coil_drive_en)
		else $error("coil off in a powered phase");
	a_ping_good: assert property (pkt_ping && rx_header == 8'h01 |-> ##[1:2] phase == 3'h3)
		else $error("strength packet did not advance");
	a_ping_other: assert property (pkt_ping && rx_header != 8'h01 |-> ##[1:2] phase == 3'h5)
		else $error("wrong packet in ping kept power");
	a_power_exit: assert property (pkt_pwr && rx_header inside {8'h01, 8'h02, 8'h51, 8'h71, 8'h81}
		|-> ##[1:2] phase == 3'h1) else $error("power kept after end or bad packet");
	a_settle_hold: assert property (pkt_pwr && rx_header == 8'h03 |=> ($stable(freq_khz) && $stable(duty_pct)) [*8])
		else $error("operating point moved before settling");
	c_power: cover property (phase == 3'h4);
	c_remove: cover property (phase == 3'h5);
	c_sleep: cover property (sleep_mode);
endmodule : wptx_chk
bind wptx_phase_ctrl wptx_chk u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .enable_n(enable_n),
	.rx_pkt_valid(rx_pkt_valid), .rx_header(rx_header), .coil_drive_en(coil_drive_en),
	.freq_khz(freq_khz), .duty_pct(duty_pct), .sleep_mode(sleep_mode), .phase(phase));
`default_nettype wire

// file: test/wptx_rx_model.sv
/* Receiver model: per request a start-bit pulse, then after a gap one packet strobe.
 * Assumes requests are held until done, on the transmitter's clock. */
`timescale 1ns/100ps
`default_nettype none
module wptx_rx_model (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Bench request
	input wire logic req,
	input wire logic [7:0] hdr,
	input wire logic [7:0] msg,
	input wire logic [7:0] gap,
	output logic done,
	// Demodulated link
	output logic rx_start_bit,
	output logic rx_pkt_valid,
	output logic [7:0] rx_header,
	output logic [7:0] rx_msg0
);
	logic busy;
	logic [7:0] cnt;
	always_ff @(posedge clk_sys) begin
		rx_start_bit <= 1'b0;
		rx_pkt_valid <= 1'b0;
		done <= 1'b0;
		// Bytes toggle outside the strobe so a stale byte never reads as valid.
		rx_header <= ~rx_header;
		rx_msg0 <= ~rx_msg0;
		if (rst) begin
			busy <= 1'b0;
			cnt <= 8'h00;
			rx_header <= 8'h00;
			rx_msg0 <= 8'h00;
		end else if (busy) begin
			cnt <= cnt - 8'h01;
			if (cnt == 8'h00) begin
				busy <= 1'b0;
				done <= 1'b1;
				rx_pkt_valid <= 1'b1;
				rx_header <= hdr;
				rx_msg0 <= msg;
			end
		end else if (req && !done) begin
			busy <= 1'b1;
			cnt <= gap;
			rx_start_bit <= 1'b1;
		end
	end
endmodule : wptx_rx_model
`default_nettype wire

// file: test/wireless_power_tx_phase_control_test.sv
/* Self-checking bench for the transmitter phase controller.
 * Assumes the receiver model and the bound port checker. */
`timescale 1ns/100ps
`default_nettype none
module wireless_power_tx_phase_control_test;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic enable_n = 1'b0;
	logic sense_resp = 1'b0;
	logic req = 1'b0;
	logic [7:0] hdr = 8'h00;
	logic [7:0] msg = 8'h00;
	logic [7:0] gap = 8'h03;
	logic done, rx_start_bit, rx_pkt_valid, coil_drive_en, sleep_mode;
	logic [7:0] rx_header, rx_msg0, freq_khz, sig_strength;
	logic [6:0] duty_pct;
	logic [2:0] phase;
	int n_fail = 0;
	int n_tests = 0;
	initial forever #10 clk_sys = ~clk_sys;
	wptx_phase_ctrl #(.PING_TMO_CYC(40), .NEXT_TMO_CYC(40), .CE_FIRST_TMO_CYC(60), .CE_TMO_CYC(100),
		.RP_TMO_CYC(150)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.enable_n(enable_n), .rx_start_bit(rx_start_bit), .rx_pkt_valid(rx_pkt_valid), .rx_header(rx_header),
		.rx_msg0(rx_msg0), .sense_resp(sense_resp), .coil_drive_en(coil_drive_en), .freq_khz(freq_khz),
		.duty_pct(duty_pct), .sleep_mode(sleep_mode), .phase(phase), .sig_strength(sig_strength));
	wptx_rx_model rx (.clk_sys(clk_sys), .rst(sys_rst), .req(req), .hdr(hdr), .msg(msg), .gap(gap),
		.done(done), .rx_start_bit(rx_start_bit), .rx_pkt_valid(rx_pkt_valid), .rx_header(rx_header),
		.rx_msg0(rx_msg0));
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic close_out();
		$display("tests=%0d fails=%0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : close_out
	task automatic cycles(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : cycles
	task automatic wait_ph(input logic [2:0] ph, input int n);
		repeat (n) begin
			@(negedge clk_sys);
			if (phase === ph) break;
		end
		check({5'h00, phase}, {5'h00, ph});
		if (phase !== ph) close_out();
	endtask : wait_ph
	task automatic send(input logic [7:0] h, input logic [7:0] m, input logic [7:0] g);
		int k;
		@(posedge clk_sys);
		req <= 1'b1;
		hdr <= h;
		msg <= m;
		gap <= g;
		for (k = 0; k < 200 && done !== 1'b1; k++) @(negedge clk_sys);
		@(posedge clk_sys);
		req <= 1'b0;
		if (k == 200) begin
			n_fail++;
			close_out();
		end
	endtask : send
	task automatic to_ping();
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		repeat (8) @(posedge clk_sys);
		sys_rst <= 1'b0;
		sense_resp <= 1'b1;
		wait_ph(3'h2, 6000);
		@(posedge clk_sys);
		sense_resp <= 1'b0;
	endtask : to_ping
	task automatic to_power(input logic ext, input int nopt);
		logic [7:0] opt [4] = '{8'h06, 8'h18, 8'hF2, 8'h20};
		to_ping();
		send(8'h01, 8'h80, 8'h03);
		send(8'h71, {ext, 7'h00}, 8'h03);
		if (ext) send(8'h81, 8'h00, 8'h3C);
		for (int i = 0; i < nopt; i++) send(opt[i % 4], 8'h00, 8'h03);
		send(8'h51, 8'h00, 8'h03);
	endtask : to_power
	task automatic t_boot();
		int k;
		check(freq_khz, 8'hAF);
		check({1'b0, duty_pct}, 8'h32);
		check({7'h00, sleep_mode}, 8'h00);
		for (k = 0; k < 6000 && coil_drive_en !== 1'b1; k++) @(negedge clk_sys);
		for (k = 0; k < 6000 && coil_drive_en === 1'b1; k++) @(negedge clk_sys);
		check(8'(k == wptx_pkg::BURST_CYC), 8'h01);
		check({5'h00, phase}, 8'h01);
	endtask : t_boot
	task automatic t_sleep();
		to_ping();
		@(posedge clk_sys);
		enable_n <= 1'b1;
		cycles(8);
		check({6'h00, sleep_mode, coil_drive_en}, 8'h02);
		@(posedge clk_sys);
		enable_n <= 1'b0;
		cycles(8);
		check({7'h00, sleep_mode}, 8'h00);
	endtask : t_sleep
	task automatic t_full();
		to_power(1'b1, 7);
		wait_ph(3'h4, 10);
		check(sig_strength, 8'h80);
		send(8'h04, 8'h00, 8'h03);
		send(8'h03, 8'h05, 8'h03);
		cycles(10);
		check(freq_khz, 8'hAF);
		cycles(20);
		check(freq_khz, 8'hAE);
		send(8'h05, 8'h00, 8'h03);
		cycles(2);
		check({5'h00, phase}, 8'h04);
		repeat (32) begin
			send(8'h03, 8'hFF, 8'h03);
			cycles(24);
		end
		check(freq_khz, 8'hCD);
		check({1'b0, duty_pct}, 8'h31);
		send(8'h02, 8'h00, 8'h03);
		wait_ph(3'h1, 5);
	endtask : t_full
	task automatic t_ping_bad();
		to_ping();
		send(8'h04, 8'h00, 8'h03);
		wait_ph(3'h5, 5);
		cycles(10);
		check({5'h00, phase}, 8'h05);
		wait_ph(3'h1, 30);
	endtask : t_ping_bad
	task automatic t_ping_tmo();
		to_ping();
		cycles(30);
		check({5'h00, phase}, 8'h02);
		wait_ph(3'h5, 20);
	endtask : t_ping_tmo
	task automatic t_opt_over();
		to_power(1'b0, 8);
		wait_ph(3'h5, 1);
		wait_ph(3'h1, 30);
	endtask : t_opt_over
	task automatic t_ce_late();
		to_power(1'b0, 0);
		wait_ph(3'h4, 10);
		send(8'h04, 8'h00, 8'h03);
		cycles(30);
		check({5'h00, phase}, 8'h04);
		wait_ph(3'h1, 40);
	endtask : t_ce_late
	task automatic t_rp_late();
		to_power(1'b0, 0);
		wait_ph(3'h4, 10);
		repeat (3) begin
			send(8'h03, 8'hFB, 8'h03);
			cycles(35);
		end
		check({5'h00, phase}, 8'h04);
		check(freq_khz, 8'hB2);
		wait_ph(3'h1, 50);
	endtask : t_rp_late
	task automatic t_seq_break();
		logic [7:0] bad [4] = '{8'h01, 8'h71, 8'h81, 8'h51};
		for (int i = 0; i < 4; i++) begin
			to_power(1'b0, 0);
			wait_ph(3'h4, 10);
			send(bad[i], 8'h00, 8'h03);
			wait_ph(3'h1, 5);
		end
	endtask : t_seq_break
	initial begin
		repeat (8) @(posedge clk_sys);
		sys_rst <= 1'b0;
		cycles(1);
		t_boot();
		t_sleep();
		t_full();
		t_ping_bad();
		t_ping_tmo();
		t_opt_over();
		t_ce_late();
		t_rp_late();
		t_seq_break();
		close_out();
	end
endmodule : wireless_power_tx_phase_control_test
`default_nettype wire
